// File: rtl/iscb_defs.svh
`ifndef ISCB_DEFS_SVH
`define ISCB_DEFS_SVH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define ISCB_OFS_RELOAD 5'h00
`define ISCB_OFS_BUFFER 5'h04
`define ISCB_OFS_CTRL 5'h08
`define ISCB_OFS_STATUS 5'h0c
`define ISCB_OFS_CLEAR 5'h10
`define ISCB_OFS_ENABLE 5'h14

// --------------------------------------------------------------
// control fields
// --------------------------------------------------------------
`define ISCB_CTRL_EN 0
`define ISCB_CTRL_SPI 1
`define ISCB_CTRL_STOP 2
`define ISCB_CTRL_START 3

// --------------------------------------------------------------
// status fields and interrupt bits
// --------------------------------------------------------------
`define ISCB_ST_SPIF 0
`define ISCB_ST_BCL 1
`define ISCB_ST_STOPDET 2
`define ISCB_ST_BUSY 3
`define ISCB_ST_LOCK 4
`define ISCB_IRQ_BITS 2

// --------------------------------------------------------------
// reset values and timing
// --------------------------------------------------------------
`define ISCB_RST_RELOAD 8'h4f
`define ISCB_RST_CTRL 8'h00
`define ISCB_XFER_HALVES 5'h10

`endif

// File: rtl/iscb_pkg.sv
package iscb_pkg;
    // stop sequence phases
    typedef enum logic [2:0] {
        STOP_IDLE,
        STOP_SDA_LOW,
        STOP_SCL_WAIT,
        STOP_SCL_HIGH,
        STOP_SDA_REL,
        STOP_TAIL
    } iscb_stop_t;
endpackage

// File: rtl/iscb_brg.sv
// reload down-counter shared by both master modes; one expiry per half clock period
module iscb_brg #(
    parameter int RW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic [RW-1:0] reload,
    input wire logic load,
    input wire logic run,
    // event
    output logic expire
);
    logic [RW:0] cnt_r;
    logic [RW:0] cnt_nxt;
    logic expire_r;
    logic expire_nxt;

    generate
        if (RW < 2) begin : g_bad_width
            $error("iscb_brg: reload width too small");
        end
    endgenerate

    // each half period is 2*(reload+1) clocks, so a full period is 4*(reload+1)
    always_comb begin
        cnt_nxt = cnt_r;
        expire_nxt = 1'b0;
        if (load) begin
            cnt_nxt = {reload, 1'b1};
        end else if (run) begin
            if (cnt_r == '0) begin
                cnt_nxt = {reload, 1'b1}; // see R08
                expire_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    // counter holds still when no operation runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            expire_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt; // see R07
            expire_r <= expire_nxt;
        end
    end

    assign expire = expire_r;
endmodule // iscb_brg

// File: rtl/iscb_top.sv
// What this block does
// R01: in a stop, sample data after the released-line count expires; low means collision.
// R02: in a stop, clock seen low again before data rises flags a collision.
// R03: stop begins driving data low; clock released only after data is sampled low.
// R04: wait for clock high, reload counter, count to zero, then release data.
// R05: one reload down-counter clocks both two-wire and serial-peripheral master modes.
// R06: writing the shift buffer starts the counter counting down.
// R07: when an operation ends the counter stops and the clock pin keeps its level.
// R08: the counter reloads from the reload register twice per clock period.
// R09: clock frequency is oscillator over four times reload plus one.
// R10: software must not use reload values 0, 1 or 2 in two-wire mode.
// R11: a collision sets the bus collision flag and returns the port to idle.
// R12: an aborted sequence releases both lines and clears its enable bit.
// R13: after a clean stop wait one more period, clear stop enable, set port flag.
// R14: after a stop collision ignore the bus until a buffer write or start request.
`include "iscb_defs.svh"

module iscb_top #(
    parameter int RW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt
    output logic irq,
    // two-wire bus pins, open drain in two-wire mode
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    generate
        if (RW != 8) begin : g_bad_width
            $error("iscb_top: register width must be 8");
        end
    endgenerate

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic scl_s1_r;
    logic scl_s2_r;
    logic sda_s1_r;
    logic sda_s2_r;

    // two flops per pin; only the second stage is read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
        end
    end

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [RW-1:0] reload_r, reload_nxt;
    logic [RW-1:0] shift_r, shift_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [`ISCB_IRQ_BITS-1:0] flags_r, flags_nxt;
    logic [`ISCB_IRQ_BITS-1:0] irq_en_r, irq_en_nxt;
    logic stop_det_r, stop_det_nxt;
    logic lock_r, lock_nxt;
    logic [4:0] halves_r, halves_nxt;
    logic clk_lvl_r, clk_lvl_nxt;
    iscb_pkg::iscb_stop_t stop_r, stop_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic scl_o_r, scl_o_nxt, scl_oe_r, scl_oe_nxt;
    logic sda_o_r, sda_o_nxt, sda_oe_r, sda_oe_nxt;
    logic brg_load;
    logic brg_run;
    logic brg_exp;

    logic take;
    logic wr_take;
    logic xfer_busy;
    logic busy;
    logic spi_mode;
    logic [`ISCB_IRQ_BITS-1:0] set_ev;

    assign take = (avs_read || avs_write) && !wait_r;
    assign wr_take = avs_write && !wait_r;
    assign xfer_busy = (halves_r != 5'h00);
    assign busy = xfer_busy || (stop_r != iscb_pkg::STOP_IDLE);
    assign spi_mode = ctrl_r[`ISCB_CTRL_SPI];

    // --------------------------------------------------------------
    // shared reload down-counter
    // --------------------------------------------------------------
    iscb_brg #(
        .RW(RW)
    ) u_brg (
        .clk(clk),
        .sys_rst(sys_rst),
        .reload(reload_r),
        .load(brg_load),
        .run(brg_run), // see R05
        .expire(brg_exp)
    );

    // read mux of the register file
    function automatic logic [31:0] rd_mux(input logic [4:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `ISCB_OFS_RELOAD: v[RW-1:0] = reload_r;
            `ISCB_OFS_BUFFER: v[RW-1:0] = shift_r;
            `ISCB_OFS_CTRL: v[7:0] = ctrl_r;
            `ISCB_OFS_STATUS: v[4:0] = {lock_r, busy, stop_det_r, flags_r};
            `ISCB_OFS_ENABLE: v[`ISCB_IRQ_BITS-1:0] = irq_en_r;
            default: v = 32'h0000_0000; // clear register and holes read zero
        endcase
        return v;
    endfunction

    // --------------------------------------------------------------
    // next-state logic: bus slave, transfer, stop sequence, pins
    // --------------------------------------------------------------
    always_comb begin
        reload_nxt = reload_r;
        shift_nxt = shift_r;
        ctrl_nxt = ctrl_r;
        irq_en_nxt = irq_en_r;
        stop_det_nxt = stop_det_r;
        lock_nxt = lock_r;
        halves_nxt = halves_r;
        clk_lvl_nxt = clk_lvl_r;
        stop_nxt = stop_r;
        set_ev = '0;
        brg_load = 1'b0;
        brg_run = busy && ctrl_r[`ISCB_CTRL_EN];
        scl_o_nxt = 1'b0;
        sda_o_nxt = 1'b0;
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        ctrl_nxt[`ISCB_CTRL_START] = 1'b0;

        // one wait cycle, then the answer stands for the completing edge
        wait_nxt = !((avs_read || avs_write) && wait_r);
        rdata_nxt = ((avs_read || avs_write) && wait_r) ? rd_mux(avs_address) : rdata_r;

        if (wr_take) begin
            unique case (avs_address)
                `ISCB_OFS_RELOAD: reload_nxt = avs_writedata[RW-1:0];
                `ISCB_OFS_BUFFER: begin
                    if (!busy && ctrl_r[`ISCB_CTRL_EN]) begin
                        shift_nxt = avs_writedata[RW-1:0];
                        halves_nxt = `ISCB_XFER_HALVES;
                        clk_lvl_nxt = 1'b0;
                        brg_load = 1'b1; // see R06
                        lock_nxt = 1'b0; // see R14
                    end
                end
                `ISCB_OFS_CTRL: begin
                    ctrl_nxt[1:0] = avs_writedata[1:0];
                    if (avs_writedata[`ISCB_CTRL_START]) begin
                        lock_nxt = 1'b0; // see R14
                    end
                    if (avs_writedata[`ISCB_CTRL_STOP] && !busy && !lock_r && !spi_mode) begin
                        ctrl_nxt[`ISCB_CTRL_STOP] = 1'b1;
                        stop_nxt = iscb_pkg::STOP_SDA_LOW;
                        stop_det_nxt = 1'b0;
                        brg_load = 1'b1;
                    end
                end
                `ISCB_OFS_ENABLE: irq_en_nxt = avs_writedata[`ISCB_IRQ_BITS-1:0];
                default: ; // status, clear and holes take no store
            endcase
        end

        // byte transfer: clock toggles on each expiry, data moves on the falling half
        if (xfer_busy && brg_exp) begin
            clk_lvl_nxt = !clk_lvl_r; // see R09
            halves_nxt = halves_r - 5'h01;
            if (clk_lvl_r) begin
                shift_nxt = {shift_r[RW-2:0], 1'b0};
            end
            if (halves_r == 5'h01) begin
                set_ev[`ISCB_ST_SPIF] = 1'b1; // counter stops, clock keeps level, see R07
            end
        end

        // stop sequence
        unique case (stop_r)
            iscb_pkg::STOP_IDLE: ;
            iscb_pkg::STOP_SDA_LOW: begin
                sda_oe_nxt = 1'b1; // see R03
                scl_oe_nxt = 1'b1;
                if (brg_exp && !sda_s2_r) begin
                    scl_oe_nxt = 1'b0; // see R03
                    stop_nxt = iscb_pkg::STOP_SCL_WAIT;
                end
            end
            iscb_pkg::STOP_SCL_WAIT: begin
                // others may stretch the clock here
                if (scl_s2_r) begin
                    brg_load = 1'b1; // see R04
                    stop_nxt = iscb_pkg::STOP_SCL_HIGH;
                end
            end
            iscb_pkg::STOP_SCL_HIGH: begin
                if (!scl_s2_r) begin
                    set_ev[`ISCB_ST_BCL] = 1'b1; // see R02
                end else if (brg_exp) begin
                    sda_oe_nxt = 1'b0;
                    brg_load = 1'b1; // see R04
                    stop_nxt = iscb_pkg::STOP_SDA_REL;
                end
            end
            iscb_pkg::STOP_SDA_REL: begin
                if (!scl_s2_r && !sda_s2_r) begin
                    set_ev[`ISCB_ST_BCL] = 1'b1; // see R02
                end else if (brg_exp) begin
                    if (!sda_s2_r) begin
                        set_ev[`ISCB_ST_BCL] = 1'b1; // see R01
                    end else begin
                        stop_det_nxt = 1'b1;
                        brg_load = 1'b1;
                        stop_nxt = iscb_pkg::STOP_TAIL;
                    end
                end
            end
            iscb_pkg::STOP_TAIL: begin
                if (brg_exp) begin
                    ctrl_nxt[`ISCB_CTRL_STOP] = 1'b0; // see R13
                    set_ev[`ISCB_ST_SPIF] = 1'b1; // see R13
                    stop_nxt = iscb_pkg::STOP_IDLE;
                end
            end
            default: stop_nxt = iscb_pkg::STOP_IDLE;
        endcase

        // collision aborts the stop: release lines, clear enable, go idle
        if (set_ev[`ISCB_ST_BCL]) begin
            sda_oe_nxt = 1'b0; // see R12
            scl_oe_nxt = 1'b0; // see R12
            ctrl_nxt[`ISCB_CTRL_STOP] = 1'b0; // see R12
            stop_nxt = iscb_pkg::STOP_IDLE; // see R11
            lock_nxt = 1'b1; // see R14
        end

        // transfer drives the pins; spi is push-pull, two-wire is open drain
        if (xfer_busy || halves_nxt != 5'h00) begin
            if (spi_mode) begin
                scl_o_nxt = clk_lvl_nxt;
                scl_oe_nxt = 1'b1;
                sda_o_nxt = shift_nxt[RW-1];
                sda_oe_nxt = 1'b1;
            end else begin
                scl_oe_nxt = !clk_lvl_nxt;
                sda_oe_nxt = !shift_nxt[RW-1];
            end
        end else if (spi_mode) begin
            scl_o_nxt = scl_o_r;
            sda_o_nxt = sda_o_r;
        end

        // disabling the port frees the pins and abandons any operation
        if (!ctrl_r[`ISCB_CTRL_EN]) begin
            scl_oe_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
            halves_nxt = 5'h00;
            stop_nxt = iscb_pkg::STOP_IDLE;
            ctrl_nxt[`ISCB_CTRL_STOP] = 1'b0;
            stop_det_nxt = 1'b0;
        end

        // sticky flags: a hardware set beats a same-cycle clear
        flags_nxt = flags_r;
        if (wr_take && avs_address == `ISCB_OFS_CLEAR) begin
            flags_nxt = flags_r & ~avs_writedata[`ISCB_IRQ_BITS-1:0];
        end
        flags_nxt = flags_nxt | set_ev; // see R11
        irq_nxt = |(flags_nxt & irq_en_nxt);
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reload_r <= `ISCB_RST_RELOAD;
            shift_r <= '0;
            ctrl_r <= `ISCB_RST_CTRL;
            flags_r <= '0;
            irq_en_r <= '0;
            stop_det_r <= 1'b0;
            lock_r <= 1'b0;
            halves_r <= 5'h00;
            clk_lvl_r <= 1'b0;
            stop_r <= iscb_pkg::STOP_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
            scl_o_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_o_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            reload_r <= reload_nxt;
            shift_r <= shift_nxt;
            ctrl_r <= ctrl_nxt;
            flags_r <= flags_nxt;
            irq_en_r <= irq_en_nxt;
            stop_det_r <= stop_det_nxt;
            lock_r <= lock_nxt;
            halves_r <= halves_nxt;
            clk_lvl_r <= clk_lvl_nxt;
            stop_r <= stop_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            scl_o_r <= scl_o_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_o_r <= sda_o_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    // outputs straight from flops
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq = irq_r;
    assign scl_o = scl_o_r;
    assign scl_oe = scl_oe_r;
    assign sda_o = sda_o_r;
    assign sda_oe = sda_oe_r;

    logic unused_take;
    assign unused_take = take;
endmodule // iscb_top

// File: tb/iscb_top_props.sv
module iscb_top_props #(
    parameter int RW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // interrupt and pin drivers
    input wire logic irq,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // every check is off while reset is high
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // bus handshake: one answer cycle per request
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_rd_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:RW] == '0)
        else $error("read data above register width");
    // pins quiet right after reset
    a_rst_quiet: assert property ($fell(sys_rst) |-> !scl_oe && !sda_oe && !irq)
        else $error("pins or irq active after reset");
    // flags are sticky: irq only drops after software writes
    a_irq_cause: assert property ($fell(irq) |-> $past(avs_write, 2) || $past(avs_write, 3))
        else $error("irq dropped without a write");
    // each clock half lasts a full counter period, reload never below 3
    a_clk_spacing: assert property ($changed(scl_oe) |=> $stable(scl_oe)[*6])
        else $error("clock pin half period too short");
    a_spi_spacing: assert property ($changed(scl_o) |=> $stable(scl_o)[*6])
        else $error("serial clock half period too short");
    // data released with clock released: stop end or abort, both lines stay free
    a_release_hold: assert property ($fell(sda_oe) && !scl_oe |=> (!sda_oe && !scl_oe)[*8])
        else $error("line driven again after release");
    a_release_wait: assert property ($fell(sda_oe) && !scl_oe |-> !$past(scl_oe, 6))
        else $error("data released too soon after clock");
endmodule // iscb_top_props

bind iscb_top iscb_top_props #(.RW(RW)) u_props (.clk(clk), .sys_rst(sys_rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_oe(sda_oe));

// File: tb/iscb_bus_peer.sv
module iscb_bus_peer (
    // clock
    input wire logic clk,
    // pins of the block
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    // what the other party is told to do
    input wire logic [3:0] stretch,
    input wire logic pull_scl,
    input wire logic pull_sda,
    // resolved lines and received bits
    output logic scl_l,
    output logic sda_l,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] str_cnt_r = 4'h0;
    logic scl_prev_r = 1'h1;
    // slow slave: holds each released clock low a while; shifts data on clock rise
    always_ff @(posedge clk) begin
        str_cnt_r <= scl_oe ? stretch : (str_cnt_r == 4'h0 ? 4'h0 : str_cnt_r - 4'h1);
        scl_prev_r <= scl_l;
        if (scl_l && !scl_prev_r) begin
            rx_byte <= {rx_byte[6:0], sda_l};
        end
    end
    // pull-ups: a released line floats high unless someone pulls it low
    assign scl_l = (scl_oe ? scl_o : str_cnt_r == 4'h0) && !pull_scl;
    assign sda_l = (sda_oe ? sda_o : 1'h1) && !pull_sda;
endmodule // iscb_bus_peer

// File: tb/iscb_top_tb.sv
`include "iscb_defs.svh"

module iscb_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, irq, scl_o, scl_oe, sda_o, sda_oe, scl_l, sda_l;
    logic [3:0] stretch = 4'h0;
    logic pull_scl = 1'h0;
    logic pull_sda = 1'h0;
    logic [7:0] rx_byte;
    int bad_count = 0;
    int tests_run = 0;

    iscb_top #(.RW(8)) uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .scl_i(scl_l), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_l), .sda_o(sda_o),
        .sda_oe(sda_oe));
    iscb_bus_peer peer (.clk(clk), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
        .sda_oe(sda_oe), .stretch(stretch), .pull_scl(pull_scl), .pull_sda(pull_sda),
        .scl_l(scl_l), .sda_l(sda_l), .rx_byte(rx_byte));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a wait that ran out counts as a mismatch and ends the run
    task automatic tmo();
        chk(32'h0, 32'h1);
        stop_test();
    endtask

    // one bus access; held until waitrequest is seen low, one idle edge after
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) begin
            n++;
            if (n > 50) tmo();
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
    endtask

    task automatic poll(input logic [7:0] m);
        int n;
        n = 0;
        bus(1'h0, `ISCB_OFS_STATUS, 8'h00);
        while ((rd[7:0] & m) === 8'h00) begin
            n++;
            if (n > 300) tmo();
            bus(1'h0, `ISCB_OFS_STATUS, 8'h00);
        end
    endtask

    // cycles until the clock line rises, less one
    task automatic rise(output int n);
        logic p;
        n = 0;
        p = scl_l;
        @(posedge clk);
        while (!(scl_l && !p)) begin
            p = scl_l;
            n++;
            if (n > 300) tmo();
            @(posedge clk);
        end
    endtask

    // wait until a pin driver lets go: sel 0 clock, 1 data
    task automatic wait_lo(input logic sel);
        int n;
        n = 0;
        while ((sel ? sda_oe : scl_oe) !== 1'h0) begin
            n++;
            if (n > 300) tmo();
            @(posedge clk);
        end
    endtask

    // send one byte, measure the clock period, check what the far side got
    task automatic byte_out(input logic [7:0] ctl, input logic [7:0] d);
        int n;
        bus(1'h1, `ISCB_OFS_CTRL, ctl);
        bus(1'h1, `ISCB_OFS_BUFFER, d);
        rise(n);
        rise(n);
        chk(n + 1, 32'h10);
        poll(8'h01);
        chk(rx_byte, d);
    endtask

    task automatic t_regs();
        bus(1'h0, `ISCB_OFS_RELOAD, 8'h00);
        chk(rd, 32'h4f);
        bus(1'h0, `ISCB_OFS_CTRL, 8'h00);
        chk(rd, 32'h0);
        bus(1'h1, `ISCB_OFS_STATUS, 8'hff);
        bus(1'h0, `ISCB_OFS_STATUS, 8'h00);
        chk(rd, 32'h0);
        bus(1'h1, 5'h18, 8'hff);
        bus(1'h0, 5'h18, 8'h00);
        chk(rd, 32'h0);
        bus(1'h1, `ISCB_OFS_RELOAD, 8'h03);
        bus(1'h0, `ISCB_OFS_RELOAD, 8'h00);
        chk(rd, 32'h03);
        bus(1'h1, `ISCB_OFS_ENABLE, 8'h03);
        $display("test regs done");
    endtask

    task automatic t_byte();
        byte_out(8'h01, 8'ha5);
        repeat (2) @(posedge clk);
        chk(irq, 1'h1);
        bus(1'h1, `ISCB_OFS_ENABLE, 8'h02);
        repeat (20) @(posedge clk);
        chk({irq, scl_oe}, 2'h1);
        bus(1'h1, `ISCB_OFS_ENABLE, 8'h03);
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'h0);
        $display("test byte done");
    endtask

    task automatic t_stop();
        byte_out(8'h01, 8'h5a);
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h01);
        stretch <= 4'h5;
        bus(1'h1, `ISCB_OFS_CTRL, 8'h05);
        wait_lo(1'h0);
        chk(sda_oe, 1'h1);
        poll(8'h04);
        chk(rd[1:0], 2'h0);
        poll(8'h01);
        bus(1'h0, `ISCB_OFS_CTRL, 8'h00);
        chk(rd, 32'h01);
        stretch <= 4'h0;
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h01);
        $display("test stop done");
    endtask

    // another master holds data low after release
    task automatic t_coll_data();
        byte_out(8'h01, 8'hc3);
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h01);
        bus(1'h1, `ISCB_OFS_CTRL, 8'h05);
        wait_lo(1'h0);
        wait_lo(1'h1);
        pull_sda <= 1'h1;
        poll(8'h02);
        chk(rd[4], 1'h1);
        chk({irq, scl_oe, sda_oe}, 3'h4);
        bus(1'h0, `ISCB_OFS_CTRL, 8'h00);
        chk(rd, 32'h01);
        bus(1'h1, `ISCB_OFS_CTRL, 8'h05);
        // read back at once: a stop that slipped past the lock would still show here
        bus(1'h0, `ISCB_OFS_CTRL, 8'h00);
        chk({rd[7:0], sda_oe}, 9'h002);
        pull_sda <= 1'h0;
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h02);
        bus(1'h1, `ISCB_OFS_CTRL, 8'h09);
        bus(1'h0, `ISCB_OFS_STATUS, 8'h00);
        chk({irq, rd[4], rd[1]}, 3'h0);
        $display("test data collision done");
    endtask

    // another master pulls the clock low before data rises
    task automatic t_coll_clock();
        byte_out(8'h01, 8'h96);
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h01);
        bus(1'h1, `ISCB_OFS_CTRL, 8'h05);
        wait_lo(1'h0);
        repeat (4) @(posedge clk);
        pull_scl <= 1'h1;
        poll(8'h02);
        bus(1'h0, `ISCB_OFS_CTRL, 8'h00);
        chk({rd[7:0], sda_oe}, 9'h002);
        pull_scl <= 1'h0;
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h02);
        $display("test clock collision done");
    endtask

    // same reload counter clocks serial-peripheral mode
    task automatic t_spi();
        byte_out(8'h03, 8'h3c);
        bus(1'h1, `ISCB_OFS_CLEAR, 8'h01);
        $display("test spi done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_byte();
        t_stop();
        t_coll_data();
        t_coll_clock();
        t_spi();
        stop_test();
    end
endmodule // iscb_top_tb
